// ===== shared/mbr_pkg.sv
/*
  Shared definitions for the drive's serial-port register access block:
  function codes, register offsets, fault record layout, setpoint limits,
  exception codes and the request/response carriers.
  Assumes framing, CRC and station matching are done upstream.
*/
package mbr_pkg;

  // ****************************************************************
  // Function codes and exception codes
  // ****************************************************************
  localparam logic [7:0] FN_READ_HOLD = 8'h03;
  localparam logic [7:0] FN_FORCE_COILS = 8'h0f;
  localparam logic [7:0] FN_PRESET_REGS = 8'h10;
  localparam logic [7:0] EXC_ILL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILL_DATA = 8'h03;

  // ****************************************************************
  // Coil write of the sequence command words
  // ****************************************************************
  localparam logic [15:0] SEQ1_ADDR = 16'h0000;
  localparam logic [15:0] SEQ2_ADDR = 16'h0020;
  localparam logic [15:0] SEQ_QTY = 16'h0020;
  localparam logic [7:0] SEQ_NBYTES = 8'h04;

  // ****************************************************************
  // Setpoint registers, two 16-bit registers each
  // ****************************************************************
  localparam logic [15:0] FREQ_SPEED_OFS = 16'h0000;
  localparam logic [15:0] TORQUE_OFS = 16'h0002;
  localparam logic [15:0] TORQUE_BIAS_OFS = 16'h0004;
  localparam logic [15:0] DRV_LIM_OFS = 16'h0006;
  localparam logic [15:0] REGEN_LIM_OFS = 16'h0008;
  localparam logic [15:0] SP_QTY = 16'h0002;
  localparam logic [7:0] SP_NBYTES = 8'h04;
  localparam int SP_COUNT = 5;
  localparam logic signed [31:0] SP_RESET = 32'sh0000_0000;
  localparam logic signed [31:0] TORQUE_MAX = 32'sd3000;
  localparam logic signed [31:0] TORQUE_MIN = -32'sd3000;
  localparam logic signed [31:0] LIM_MAX = 32'sd1000;
  localparam logic signed [31:0] LIM_MIN = 32'sd0;

  // ****************************************************************
  // Fault history blocks and record layout
  // ****************************************************************
  localparam logic [15:0] FLT_BASE = 16'h0063;
  localparam logic [15:0] FLT_STRIDE = 16'h0010;
  localparam logic [15:0] FLT_QTY = 16'h0010;
  localparam int FLT_BLOCKS = 8;
  localparam int FLT_ITEMS = 8;
  localparam logic [2:0] IT_PRIMARY = 3'h0;
  localparam logic [2:0] IT_SECONDARY = 3'h1;
  localparam logic [2:0] IT_FREQ = 3'h2;
  localparam logic [2:0] IT_CURRENT = 3'h3;
  localparam logic [2:0] IT_DC_VOLT = 3'h4;
  localparam logic [2:0] IT_HW_FAULT = 3'h5;
  localparam logic [2:0] IT_POWER_HOURS = 3'h6;
  localparam logic [2:0] IT_RUN_HOURS = 3'h7;
  localparam logic [31:0] HW_FAULT_MASK = 32'h0000_00ff;

  typedef struct packed {
    logic valid;
    logic [7:0] func;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [7:0] nbytes;
    logic [31:0] data;
  } mbr_req_t;

  typedef struct packed {
    logic valid;
    logic exc;
    logic [7:0] code;
    logic [31:0] data;
    logic last;
  } mbr_rsp_t;

  typedef struct packed {
    logic we;
    logic [2:0] block;
    logic [2:0] item;
    logic [31:0] data;
  } mbr_flt_wr_t;

endpackage

// ===== verilog/mbr_record_mem.sv
/*
  Fault history storage: one write port, one read port, registered read data.
  Assumes the caller keeps addresses in range.
*/
`timescale 1ns/1ps
module mbr_record_mem #(
  parameter int DW = 32,
  parameter int AW = 6
) (
  input wire logic clk_i, // Clock.
  input wire logic we_i, // Write enable.
  input wire logic [AW-1:0] wr_addr_i, // Write address.
  input wire logic [DW-1:0] wr_data_i, // Write data.
  input wire logic [AW-1:0] rd_addr_i, // Read address.
  output logic [DW-1:0] rd_data_o // Read data, one cycle late.
);

  logic [DW-1:0] mem_reg [0:(1<<AW)-1];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[wr_addr_i] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    rd_data_o <= mem_reg[rd_addr_i];
  end

endmodule // mbr_record_mem

// ===== verilog/mbr_drive_regs.sv
/*
  Request interpreter for the drive's serial register access: coil writes of
  the sequence command words, setpoint writes and reads, fault record reads.
  Assumes requests arrive decoded with CRC checked, and that fault records
  are filled by the drive's protection logic over the capture port.
*/
// Overview of operation
// - Fault block read returns exactly 32 bytes.
// - Record is eight 4-byte items in fixed order.
// - Frequency, current, voltage items keep their scaling.
// - Hardware fault item holds 8 bits only.
// - Coil write: qty 0020h, 4 bytes, start 0000h/0020h.
// - Whole 32-bit sequence word applied at once.
// - Setpoint write: two registers, byte count 04h.
// - 0000h frequency/speed, bounded by maximum parameter.
// - Torque and bias signed, within plus/minus 300.0%.
// - Limiter reductions within 0.0 to 100.0%.
// - Unit selector 0 means 0.01 Hz / 0.1 rpm.
`timescale 1ns/1ps
module mbr_drive_regs import mbr_pkg::*; #(
  parameter int DW = 32
) (
  input wire logic clk_i, // Clock, 125 MHz.
  input wire logic rst_i, // Synchronous reset, active high.
  input wire mbr_req_t req_i, // Decoded request, valid for one cycle.
  input wire mbr_flt_wr_t flt_wr_i, // Fault record capture port.
  input wire logic vector_mode_i, // High in vector control.
  input wire logic [1:0] speed_unit_selector_i, // Setpoint unit selection.
  input wire logic signed [DW-1:0] max_frequency_param_i, // Frequency bound.
  input wire logic signed [DW-1:0] max_speed_param_i, // Speed bound.
  output mbr_rsp_t rsp_o, // Response word.
  output logic busy_o, // High while a fault record streams out.
  output logic [DW-1:0] seq_cmd1_o, // Sequence command word 1.
  output logic [DW-1:0] seq_cmd2_o, // Sequence command word 2.
  output logic [1:0] seq_load_o, // One-cycle load pulse per word.
  output logic [1:0] speed_unit_o, // Unit that the setpoint is held in.
  output logic signed [DW-1:0] freq_speed_setpoint_o, // Frequency or speed.
  output logic signed [DW-1:0] torque_setpoint_o, // Torque, 0.1%.
  output logic signed [DW-1:0] torque_bias_setpoint_o, // Torque bias, 0.1%.
  output logic signed [DW-1:0] drive_torque_limit_reduction_o, // 0.1%.
  output logic signed [DW-1:0] regen_torque_limit_reduction_o // 0.1%.
);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic in_range(input logic signed [DW-1:0] v, lo, hi);
    in_range = (v >= lo) && (v <= hi);
  endfunction
  // Fault blocks sit at 0063h plus a multiple of 0010h.
  function automatic logic flt_hit(input logic [15:0] a);
    logic [15:0] d;
    d = a - FLT_BASE;
    flt_hit = (a >= FLT_BASE) && (d[3:0] == 4'h0) && (d[15:4] < 12'(FLT_BLOCKS));
  endfunction
  typedef enum {ACT_NONE, ACT_SEQ, ACT_SET, ACT_RDREG, ACT_RDFLT, ACT_EXC} mbr_act_t;
  typedef enum {ST_IDLE, ST_FLT} mbr_state_t;
  mbr_state_t state_reg;
  mbr_act_t act;
  logic [7:0] exc_code;
  logic sp_addr_ok;
  logic [2:0] sp_idx;
  logic [2:0] flt_blk;
  logic signed [DW-1:0] sp_reg [0:SP_COUNT-1];
  logic signed [DW-1:0] bound;
  logic value_ok;
  logic [2:0] cnt_reg, blk_reg;
  logic pend_reg, pend_last_reg, busy_reg;
  logic [DW-1:0] mem_rd;
  logic [DW-1:0] cap_data;
  logic [15:0] flt_ofs;
  assign sp_addr_ok = (req_i.addr <= REGEN_LIM_OFS) && !req_i.addr[0];
  assign sp_idx = req_i.addr[3:1];
  assign flt_ofs = req_i.addr - FLT_BASE;
  assign flt_blk = flt_ofs[6:4];
  // Bound follows control mode; both sides are in the selected unit.
  assign bound = vector_mode_i ? max_speed_param_i : max_frequency_param_i;
  always_comb begin
    value_ok = 1'b0;
    case (sp_idx)
      3'd0: value_ok = in_range(req_i.data, -bound, bound);
      3'd1, 3'd2: value_ok = in_range(req_i.data, TORQUE_MIN, TORQUE_MAX);
      default: value_ok = in_range(req_i.data, LIM_MIN, LIM_MAX);
    endcase
  end

  // ****************************************************************
  // Request decode
  // ****************************************************************
  always_comb begin
    act = ACT_NONE;
    exc_code = EXC_ILL_FUNC;
    if (!req_i.valid || busy_reg) begin
      act = ACT_NONE;
    end else if (req_i.func == FN_FORCE_COILS) begin
      if (req_i.addr != SEQ1_ADDR && req_i.addr != SEQ2_ADDR) begin
        act = ACT_EXC;
        exc_code = EXC_ILL_ADDR;
      end else if (req_i.qty != SEQ_QTY || req_i.nbytes != SEQ_NBYTES) begin
        act = ACT_EXC;
        exc_code = EXC_ILL_DATA;
      end else begin
        act = ACT_SEQ;
      end
    end else if (req_i.func == FN_PRESET_REGS) begin
      if (!sp_addr_ok) begin
        act = ACT_EXC;
        exc_code = EXC_ILL_ADDR;
      end else if (req_i.qty != SP_QTY || req_i.nbytes != SP_NBYTES || !value_ok) begin
        act = ACT_EXC;
        exc_code = EXC_ILL_DATA;
      end else begin
        act = ACT_SET;
      end
    end else if (req_i.func == FN_READ_HOLD) begin
      if (sp_addr_ok && req_i.qty == SP_QTY) begin
        act = ACT_RDREG;
      end else if (flt_hit(req_i.addr) && req_i.qty == FLT_QTY) begin
        act = ACT_RDFLT;
      end else begin
        act = ACT_EXC;
        exc_code = EXC_ILL_ADDR;
      end
    end else begin
      act = ACT_EXC;
    end
  end

  // ****************************************************************
  // Sequence command words
  // ****************************************************************
  // The full word is taken from one request, so no half-updated word is ever seen.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq_cmd1_o <= '0;
      seq_cmd2_o <= '0;
      seq_load_o <= 2'b00;
    end else begin
      seq_load_o <= 2'b00;
      if (act == ACT_SEQ && req_i.addr == SEQ1_ADDR) begin
        seq_cmd1_o <= req_i.data;
        seq_load_o <= 2'b01;
      end
      if (act == ACT_SEQ && req_i.addr == SEQ2_ADDR) begin
        seq_cmd2_o <= req_i.data;
        seq_load_o <= 2'b10;
      end
    end
  end

  // ****************************************************************
  // Setpoints
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < SP_COUNT; i++) begin
        sp_reg[i] <= SP_RESET;
      end
      speed_unit_o <= 2'b00;
    end else if (act == ACT_SET) begin
      sp_reg[sp_idx] <= req_i.data;
      if (sp_idx == 3'd0) begin
        speed_unit_o <= speed_unit_selector_i;
      end
    end
  end

  assign freq_speed_setpoint_o = sp_reg[0];
  assign torque_setpoint_o = sp_reg[1];
  assign torque_bias_setpoint_o = sp_reg[2];
  assign drive_torque_limit_reduction_o = sp_reg[3];
  assign regen_torque_limit_reduction_o = sp_reg[4];

  // ****************************************************************
  // Fault record store and streaming
  // ****************************************************************
  // Capture narrows the hardware fault item so reads never show stray bits.
  assign cap_data = (flt_wr_i.item == IT_HW_FAULT) ? (flt_wr_i.data & HW_FAULT_MASK)
                                                    : flt_wr_i.data;
  mbr_record_mem #(.DW(DW), .AW(6)) u_mem (
    .clk_i(clk_i),
    .we_i(flt_wr_i.we),
    .wr_addr_i({flt_wr_i.block, flt_wr_i.item}),
    .wr_data_i(cap_data),
    .rd_addr_i({blk_reg, cnt_reg}),
    .rd_data_o(mem_rd)
  );
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 3'd0;
      blk_reg <= 3'd0;
      pend_reg <= 1'b0;
      pend_last_reg <= 1'b0;
    end else begin
      pend_reg <= (state_reg == ST_FLT);
      pend_last_reg <= (state_reg == ST_FLT) && (cnt_reg == 3'(FLT_ITEMS - 1));
      case (state_reg)
        ST_IDLE: begin
          if (act == ACT_RDFLT) begin
            state_reg <= ST_FLT;
            blk_reg <= flt_blk;
            cnt_reg <= 3'd0;
          end
        end
        ST_FLT: begin
          cnt_reg <= cnt_reg + 3'd1;
          if (cnt_reg == 3'(FLT_ITEMS - 1)) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
  // Busy covers the whole burst so single answers cannot interleave with it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
    end else if (act == ACT_RDFLT) begin
      busy_reg <= 1'b1;
    end else if (pend_last_reg) begin
      busy_reg <= 1'b0;
    end
  end
  assign busy_o = busy_reg;

  // ****************************************************************
  // Response
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o <= '0;
      if (pend_reg) begin
        rsp_o.valid <= 1'b1;
        rsp_o.data <= mem_rd;
        rsp_o.last <= pend_last_reg;
      end else if (act == ACT_EXC) begin
        rsp_o.valid <= 1'b1;
        rsp_o.exc <= 1'b1;
        rsp_o.code <= exc_code;
        rsp_o.last <= 1'b1;
      end else if (act == ACT_RDREG) begin
        rsp_o.valid <= 1'b1;
        rsp_o.data <= sp_reg[sp_idx];
        rsp_o.last <= 1'b1;
      end else if (act == ACT_SEQ || act == ACT_SET) begin
        rsp_o.valid <= 1'b1;
        rsp_o.last <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence flt_accept_s;
    act == ACT_RDFLT;
  endsequence
  sequence flt_burst_s;
    (rsp_o.valid && !rsp_o.last && !rsp_o.exc)[*7] ##1 (rsp_o.valid && rsp_o.last);
  endsequence
  fault_burst_len_a: assert property (flt_accept_s |-> ##3 flt_burst_s)
    else $error("fault record burst is not eight words");
  hw_item_narrow_a: assert property (flt_wr_i.we && flt_wr_i.item == IT_HW_FAULT
      |=> $past(cap_data[31:8]) == 24'h0)
    else $error("hardware fault item wider than 8 bits");
  seq_word_load_a: assert property (act == ACT_SEQ && req_i.addr == SEQ2_ADDR
      |=> seq_load_o == 2'b10 && seq_cmd2_o == $past(req_i.data))
    else $error("sequence word 2 not loaded whole");
  seq_bad_qty_a: assert property (req_i.valid && !busy_reg && req_i.func == FN_FORCE_COILS
      && req_i.qty != SEQ_QTY |=> rsp_o.exc && seq_load_o == 2'b00)
    else $error("coil write with wrong quantity accepted");
  preset_ack_a: assert property (act == ACT_SET |=> rsp_o.valid && !rsp_o.exc)
    else $error("setpoint write not acknowledged");
  torque_in_range_a: assert property (in_range(torque_setpoint_o, TORQUE_MIN, TORQUE_MAX)
      && in_range(torque_bias_setpoint_o, TORQUE_MIN, TORQUE_MAX))
    else $error("torque setpoint out of range");
  limit_in_range_a: assert property (in_range(drive_torque_limit_reduction_o, LIM_MIN, LIM_MAX)
      && in_range(regen_torque_limit_reduction_o, LIM_MIN, LIM_MAX))
    else $error("limiter reduction out of range");
  freq_bounded_a: assert property ($changed(freq_speed_setpoint_o)
      |-> in_range(freq_speed_setpoint_o, -$past(bound), $past(bound)))
    else $error("frequency setpoint beyond maximum");
  exc_keeps_a: assert property (act == ACT_EXC |=> rsp_o.exc
      && $stable(torque_setpoint_o) && $stable(freq_speed_setpoint_o))
    else $error("exception changed a stored value");

endmodule // mbr_drive_regs

// ===== test/mbr_master_model.sv
/*
  Model of the serial master that issues decoded requests to the block.
  Assumes requests are launched on the falling edge of the clock.
*/
`timescale 1ns/1ps
module mbr_master_model import mbr_pkg::*; (
  input wire logic clk_i, // Clock.
  output mbr_req_t req_o, // Request to the block.
  input wire mbr_rsp_t rsp_i // Response words from the block.
);
  mbr_rsp_t rsp_q[$];

  initial req_o = '0;

  // ****************************************************************
  // One transfer: request for one cycle, then collect every word
  // ****************************************************************
  task automatic xfer(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q,
                      input logic [7:0] nb, input logic [31:0] d);
    int k;
    rsp_q.delete();
    @(negedge clk_i);
    req_o <= {1'b1, f, a, q, nb, d};
    @(negedge clk_i);
    // Released fields are scrambled so that nothing leans on stale values.
    req_o <= {1'b0, ~f, ~a, ~q, ~nb, ~d};
    for (k = 0; k < 16; k++) begin
      if (rsp_i.valid === 1'b1) begin
        rsp_q.push_back(rsp_i);
        if (rsp_i.last === 1'b1 || rsp_i.exc === 1'b1) break;
      end
      @(negedge clk_i);
    end
  endtask
endmodule // mbr_master_model

// ===== test/tb.sv
/*
  Self-checking bench for the register access block.
  Assumes the master model drives requests and the bench drives the rest.
*/
`timescale 1ns/1ps
module tb;
  import mbr_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  mbr_req_t req;
  mbr_rsp_t rsp;
  mbr_flt_wr_t flt_wr = '0;
  logic vmode = 1'b0;
  logic [1:0] unit_sel = 2'h0;
  logic signed [31:0] fmax = 32'sd6000;
  logic signed [31:0] smax = 32'sd18000;
  logic busy;
  logic [31:0] seq1, seq2;
  logic [1:0] seq_load, unit;
  logic signed [31:0] fs, tq, tbias, dlim, rlim;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int busy_cyc = 0;

  always #4 clk_i = ~clk_i;

  mbr_master_model u_master (.clk_i(clk_i), .req_o(req), .rsp_i(rsp));

  mbr_drive_regs u_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .flt_wr_i(flt_wr),
    .vector_mode_i(vmode), .speed_unit_selector_i(unit_sel),
    .max_frequency_param_i(fmax), .max_speed_param_i(smax), .rsp_o(rsp),
    .busy_o(busy), .seq_cmd1_o(seq1), .seq_cmd2_o(seq2), .seq_load_o(seq_load),
    .speed_unit_o(unit), .freq_speed_setpoint_o(fs), .torque_setpoint_o(tq),
    .torque_bias_setpoint_o(tbias), .drive_torque_limit_reduction_o(dlim),
    .regen_torque_limit_reduction_o(rlim));

  always @(negedge clk_i) if (busy === 1'b1) busy_cyc++;

  // ****************************************************************
  // Shared checks
  // ****************************************************************
  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      $display("Error at %0t: timeout waiting for the scenarios to end", $time);
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  // Single-word transfer; a zero code means success is expected.
  task automatic one(input logic [7:0] f, input logic [15:0] a, input logic [15:0] q,
                     input logic [7:0] nb, input logic [31:0] d, input logic [7:0] ec);
    u_master.xfer(f, a, q, nb, d);
    chk(u_master.rsp_q.size(), 1, "response count");
    chk(u_master.rsp_q[0].exc, ec != 8'h00, "exception flag");
    if (ec != 8'h00) chk(u_master.rsp_q[0].code, ec, "exception code");
  endtask

  task automatic wr_sp(input logic [15:0] a, input logic [31:0] d, input logic [7:0] ec);
    one(FN_PRESET_REGS, a, SP_QTY, SP_NBYTES, d, ec);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_torque;
    wr_sp(TORQUE_OFS, 32'h0000_03e8, 8'h00);
    chk(tq, 32'h0000_03e8, "torque");
    wr_sp(TORQUE_OFS, 32'hffff_f448, 8'h00);
    wr_sp(TORQUE_OFS, 32'h0000_0bb9, EXC_ILL_DATA);
    chk(tq, 32'hffff_f448, "torque kept");
    wr_sp(TORQUE_BIAS_OFS, 32'hffff_f447, EXC_ILL_DATA);
    wr_sp(TORQUE_BIAS_OFS, 32'h0000_0bb8, 8'h00);
    chk(tbias, 32'h0000_0bb8, "bias");
    wr_sp(16'h0003, 32'h0000_0001, EXC_ILL_ADDR);
    wr_sp(16'h000a, 32'h0000_0001, EXC_ILL_ADDR);
    one(FN_PRESET_REGS, TORQUE_OFS, 16'h0001, SP_NBYTES, 32'h1, EXC_ILL_DATA);
    one(FN_PRESET_REGS, TORQUE_OFS, SP_QTY, 8'h02, 32'h1, EXC_ILL_DATA);
    one(FN_READ_HOLD, TORQUE_OFS, SP_QTY, 8'h00, 32'h0, 8'h00);
    chk(u_master.rsp_q[0].data, 32'hffff_f448, "torque readback");
    one(8'h06, TORQUE_OFS, SP_QTY, SP_NBYTES, 32'h1, EXC_ILL_FUNC);
  endtask

  task automatic t_limits;
    wr_sp(DRV_LIM_OFS, 32'h0000_03e8, 8'h00);
    wr_sp(DRV_LIM_OFS, 32'h0000_03e9, EXC_ILL_DATA);
    wr_sp(REGEN_LIM_OFS, 32'h0000_03e8, 8'h00);
    wr_sp(REGEN_LIM_OFS, 32'hffff_ffff, EXC_ILL_DATA);
    chk(dlim, 32'h0000_03e8, "drive limiter");
    chk(rlim, 32'h0000_03e8, "regen limiter");
  endtask

  task automatic t_freq;
    wr_sp(FREQ_SPEED_OFS, 32'h0000_1770, 8'h00);
    chk(fs, 32'h0000_1770, "frequency");
    chk(unit, 32'h0, "unit default");
    wr_sp(FREQ_SPEED_OFS, 32'hffff_e88f, EXC_ILL_DATA);
    @(negedge clk_i);
    vmode = 1'b1;
    unit_sel = 2'h1;
    wr_sp(FREQ_SPEED_OFS, 32'hffff_b9b0, 8'h00);
    chk(fs, 32'hffff_b9b0, "speed");
    chk(unit, 32'h1, "unit copy");
    wr_sp(FREQ_SPEED_OFS, 32'h0000_4651, EXC_ILL_DATA);
    chk(fs, 32'hffff_b9b0, "speed kept");
  endtask

  task automatic t_seq;
    one(FN_FORCE_COILS, SEQ1_ADDR, SEQ_QTY, SEQ_NBYTES, 32'h0123_4567, 8'h00);
    chk(seq_load, 32'h1, "load word 1");
    chk(seq1, 32'h0123_4567, "word 1");
    @(negedge clk_i);
    chk(seq_load, 32'h0, "load pulse width");
    one(FN_FORCE_COILS, SEQ2_ADDR, SEQ_QTY, SEQ_NBYTES, 32'h89ab_cdef, 8'h00);
    chk(seq_load, 32'h2, "load word 2");
    chk(seq2, 32'h89ab_cdef, "word 2");
    one(FN_FORCE_COILS, SEQ2_ADDR, 16'h001f, SEQ_NBYTES, 32'h0, EXC_ILL_DATA);
    one(FN_FORCE_COILS, 16'h0010, SEQ_QTY, SEQ_NBYTES, 32'h0, EXC_ILL_ADDR);
    chk(seq2, 32'h89ab_cdef, "word 2 kept");
    chk(seq1, 32'h0123_4567, "word 1 kept");
  endtask

  task automatic t_fault;
    logic [31:0] v [8];
    int i;
    v = '{32'h203, 32'h40d, 32'h3e8, 32'h5f, 32'h13a, 32'h1234, 32'h7, 32'h9};
    for (i = 0; i < 8; i++) begin
      @(negedge clk_i);
      flt_wr <= {1'b1, 3'h1, i[2:0], v[i]};
    end
    @(negedge clk_i);
    flt_wr <= '0;
    busy_cyc = 0;
    u_master.xfer(FN_READ_HOLD, 16'h0073, FLT_QTY, 8'h00, 32'h0);
    chk(u_master.rsp_q.size(), 8, "record words");
    for (i = 0; i < u_master.rsp_q.size(); i++) begin
      chk(u_master.rsp_q[i].data, (i == 5) ? 32'h34 : v[i], "record item");
      chk(u_master.rsp_q[i].last, i == 7, "record last");
    end
    chk(u_master.rsp_q[2].data, 32'h3e8, "frequency item");
    chk(u_master.rsp_q[5].data & ~HW_FAULT_MASK, 32'h0, "hw fault width");
    chk(busy_cyc, 9, "busy length");
    one(FN_READ_HOLD, 16'h0064, FLT_QTY, 8'h00, 32'h0, EXC_ILL_ADDR);
    one(FN_READ_HOLD, 16'h00e3, FLT_QTY, 8'h00, 32'h0, EXC_ILL_ADDR);
  endtask

  initial begin
    repeat (10) @(negedge clk_i);
    rst_i = 1'b0;
    t_torque();
    t_limits();
    t_freq();
    t_seq();
    t_fault();
    finish_test();
  end
endmodule // tb
